// File: design/lpm_pkg.sv
// Constants and types of the low-power mode select block
package lpm_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] LPM_CTRL_OFS = 8'h00;
	localparam logic [7:0] LPM_STAT_OFS = 8'h04;
	localparam logic [7:0] LPM_CTRL_RST = 8'h00;
	localparam int LPM_STBY_SEL_BIT = 7;
	localparam int LPM_WSEL_HI_BIT = 6;
	localparam int LPM_WSEL_LO_BIT = 4;
	localparam int LPM_LSR_BIT = 3;
	localparam logic [7:0] LPM_CTRL_WMASK = 8'hf8;

	// ----------------------------------------
	// Standby wait lengths in states
	// ----------------------------------------
	localparam int LPM_CNT_W = 18;
	localparam int LPM_WAIT_000 = 8192;
	localparam int LPM_WAIT_001 = 16384;
	localparam int LPM_WAIT_010 = 65536;
	localparam int LPM_WAIT_011 = 32768;
	localparam int LPM_WAIT_100 = 131072;
	localparam int LPM_WAIT_101 = 2;
	localparam int LPM_WAIT_110 = 16;
	localparam int LPM_WAIT_111 = 8;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [6:0] {
		LPM_ACTIVE = 7'h01,
		LPM_SLEEP = 7'h02,
		LPM_SUB_ACTIVE = 7'h04,
		LPM_SUB_SLEEP = 7'h08,
		LPM_STANDBY = 7'h10,
		LPM_WATCH = 7'h20,
		LPM_SETTLE = 7'h40
	} lpm_mode_t;

	typedef struct packed {
		logic standby_select;
		logic wait_time_sel_hi;
		logic wait_time_sel_mid;
		logic wait_time_sel_lo;
		logic low_speed_resume;
		logic [2:0] rsvd;
	} lpm_ctrl_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} lpm_wb_req_t;

endpackage

// File: design/lpm_wait_timer.sv
// Down counter that times the standby settle period
`timescale 1ns/1ps
module lpm_wait_timer
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic start_i,
	input wire logic [lpm_pkg::LPM_CNT_W-1:0] len_i,
	// Status
	output logic done_o
);
	logic [lpm_pkg::LPM_CNT_W-1:0] cnt_r;
	logic busy_r;

	assign done_o = busy_r && (cnt_r == '0);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			busy_r <= 1'b0;
		else if (start_i)
			busy_r <= 1'b1;
		else if (done_o)
			busy_r <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cnt_r <= '0;
		else if (start_i)
			cnt_r <= len_i - 1'b1;
		else if (busy_r && cnt_r != '0)
			cnt_r <= cnt_r - 1'b1;
	end

endmodule // lpm_wait_timer

// File: design/lpm_mode_select.sv
// Low-power mode select: control register, mode sequencer and settle wait
`timescale 1ns/1ps
module lpm_mode_select
#(
	parameter int WAIT_000 = lpm_pkg::LPM_WAIT_000,
	parameter int WAIT_001 = lpm_pkg::LPM_WAIT_001,
	parameter int WAIT_010 = lpm_pkg::LPM_WAIT_010,
	parameter int WAIT_011 = lpm_pkg::LPM_WAIT_011,
	parameter int WAIT_100 = lpm_pkg::LPM_WAIT_100,
	parameter int WAIT_110 = lpm_pkg::LPM_WAIT_110
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// CPU events
	input wire logic sleep_exec_i,
	input wire logic wake_irq_i,
	input wire logic watch_enable_i,
	// Mode outputs
	output lpm_pkg::lpm_mode_t mode_o,
	output logic cpu_hold_o,
	output logic cpu_clk_sub_o
);
	lpm_pkg::lpm_wb_req_t req;
	lpm_pkg::lpm_ctrl_t ctrl_r;
	lpm_pkg::lpm_mode_t mode_r;
	lpm_pkg::lpm_mode_t mode_nxt;
	logic ack_r;
	logic [31:0] dat_r;
	logic acc;
	logic settle_start;
	logic settle_done;
	logic [lpm_pkg::LPM_CNT_W-1:0] wait_len;

	// ----------------------------------------
	// Wait length decode
	// ----------------------------------------
	function automatic logic [lpm_pkg::LPM_CNT_W-1:0] wait_states(input logic [2:0] code);
		int n;
		n = 0;
		unique case (code)
			3'h0: n = WAIT_000;
			3'h1: n = WAIT_001;
			3'h2: n = WAIT_010;
			3'h3: n = WAIT_011;
			3'h4: n = WAIT_100;
			3'h5: n = lpm_pkg::LPM_WAIT_101;
			3'h6: n = WAIT_110;
			3'h7: n = lpm_pkg::LPM_WAIT_111;
		endcase
		return n[lpm_pkg::LPM_CNT_W-1:0];
	endfunction

	assign wait_len = wait_states({ctrl_r.wait_time_sel_hi, ctrl_r.wait_time_sel_mid,
		ctrl_r.wait_time_sel_lo});

	// ----------------------------------------
	// Wishbone register access
	// ----------------------------------------
	assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i, sel: sel_i, dat: dat_i};
	assign acc = req.cyc && req.stb && !ack_r;
	assign ack_o = ack_r;
	assign dat_o = dat_r;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= acc;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_r <= lpm_pkg::LPM_CTRL_RST;
		else if (acc && req.we && req.sel[0] && req.adr == lpm_pkg::LPM_CTRL_OFS)
			ctrl_r <= req.dat[7:0] & lpm_pkg::LPM_CTRL_WMASK;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_r <= 32'h0000_0000;
		else if (acc && !req.we)
		begin
			if (req.adr == lpm_pkg::LPM_CTRL_OFS)
				dat_r <= {24'h00_0000, ctrl_r};
			else if (req.adr == lpm_pkg::LPM_STAT_OFS)
				dat_r <= {24'h00_0000, cpu_clk_sub_o, mode_r};
			else
				dat_r <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Mode sequencer
	// ----------------------------------------
	always_comb
	begin
		mode_nxt = mode_r;
		settle_start = 1'b0;
		unique case (mode_r)
			lpm_pkg::LPM_ACTIVE:
				if (sleep_exec_i)
				begin
					if (!ctrl_r.standby_select)
						mode_nxt = lpm_pkg::LPM_SLEEP;
					else if (watch_enable_i)
						mode_nxt = lpm_pkg::LPM_WATCH;
					else
						mode_nxt = lpm_pkg::LPM_STANDBY;
				end
			lpm_pkg::LPM_SUB_ACTIVE:
				if (sleep_exec_i)
					mode_nxt = ctrl_r.standby_select ? lpm_pkg::LPM_WATCH
						: lpm_pkg::LPM_SUB_SLEEP;
			lpm_pkg::LPM_SLEEP:
				if (wake_irq_i)
					mode_nxt = lpm_pkg::LPM_ACTIVE;
			lpm_pkg::LPM_SUB_SLEEP:
				if (wake_irq_i)
					mode_nxt = lpm_pkg::LPM_SUB_ACTIVE;
			lpm_pkg::LPM_STANDBY:
				if (wake_irq_i)
				begin
					mode_nxt = lpm_pkg::LPM_SETTLE;
					settle_start = 1'b1;
				end
			lpm_pkg::LPM_WATCH:
				if (wake_irq_i)
				begin
					if (ctrl_r.low_speed_resume)
						mode_nxt = lpm_pkg::LPM_SUB_ACTIVE;
					else
					begin
						mode_nxt = lpm_pkg::LPM_SETTLE;
						settle_start = 1'b1;
					end
				end
			lpm_pkg::LPM_SETTLE:
				if (settle_done)
					mode_nxt = lpm_pkg::LPM_ACTIVE;
			default:
				mode_nxt = lpm_pkg::LPM_ACTIVE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mode_r <= lpm_pkg::LPM_ACTIVE;
		else
			mode_r <= mode_nxt;
	end

	lpm_wait_timer u_wait
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(settle_start),
		.len_i(wait_len),
		.done_o(settle_done)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign mode_o = mode_r;
	assign cpu_hold_o = !(mode_r == lpm_pkg::LPM_ACTIVE || mode_r == lpm_pkg::LPM_SUB_ACTIVE);
	assign cpu_clk_sub_o = (mode_r == lpm_pkg::LPM_SUB_ACTIVE)
		|| (mode_r == lpm_pkg::LPM_SUB_SLEEP)
		|| (mode_r == lpm_pkg::LPM_WATCH && ctrl_r.low_speed_resume);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	int settle_cnt;
	always_ff @(posedge clk_i)
	begin
		if (rst_i || mode_r != lpm_pkg::LPM_SETTLE)
			settle_cnt <= 0;
		else
			settle_cnt <= settle_cnt + 1;
	end

	AST_SLEEP_ENTRY: assert property (
		mode_r == lpm_pkg::LPM_ACTIVE && sleep_exec_i && !ctrl_r.standby_select
		|=> mode_r == lpm_pkg::LPM_SLEEP && cpu_hold_o)
		else $error("sleep not entered from active");
	AST_SUBSLEEP_ENTRY: assert property (
		mode_r == lpm_pkg::LPM_SUB_ACTIVE && sleep_exec_i && !ctrl_r.standby_select
		|=> mode_r == lpm_pkg::LPM_SUB_SLEEP)
		else $error("sub-sleep not entered");
	AST_STANDBY_ENTRY: assert property (
		$rose(mode_r == lpm_pkg::LPM_STANDBY || mode_r == lpm_pkg::LPM_WATCH)
		|-> $past(ctrl_r.standby_select) && $past(sleep_exec_i))
		else $error("standby or watch entered without standby select");
	AST_SETTLE_LEN: assert property (
		mode_r == lpm_pkg::LPM_SETTLE && mode_nxt == lpm_pkg::LPM_ACTIVE
		|-> settle_cnt + 1 == int'(wait_len))
		else $error("settle wait length wrong");
	AST_SETTLE_HOLD: assert property (
		mode_r == lpm_pkg::LPM_SETTLE |-> cpu_hold_o && !cpu_clk_sub_o)
		else $error("cpu released during settle");
	AST_SHORT_WAIT: assert property (
		settle_start && {ctrl_r.wait_time_sel_hi, ctrl_r.wait_time_sel_mid,
		ctrl_r.wait_time_sel_lo} == 3'h5 && !sleep_exec_i
		|=> mode_r == lpm_pkg::LPM_SETTLE ##2 mode_r == lpm_pkg::LPM_ACTIVE)
		else $error("two-state wait not honoured");
	AST_WATCH_RESUME: assert property (
		mode_r == lpm_pkg::LPM_WATCH && wake_irq_i
		|=> (mode_r == lpm_pkg::LPM_SUB_ACTIVE) == $past(ctrl_r.low_speed_resume))
		else $error("watch resume clock wrong");
	AST_CLK_SEL: assert property (
		cpu_clk_sub_o |-> mode_r inside {lpm_pkg::LPM_SUB_ACTIVE, lpm_pkg::LPM_SUB_SLEEP,
		lpm_pkg::LPM_WATCH})
		else $error("sub clock selected in wrong mode");
	AST_CTRL_WRITE: assert property (
		acc && req.we && req.sel[0] && req.adr == lpm_pkg::LPM_CTRL_OFS
		|=> ctrl_r.standby_select == $past(req.dat[lpm_pkg::LPM_STBY_SEL_BIT]))
		else $error("standby select not written");
	AST_LONG_CODE: assert property (
		{ctrl_r.wait_time_sel_hi, ctrl_r.wait_time_sel_mid, ctrl_r.wait_time_sel_lo} == 3'h6
		|-> wait_len == WAIT_110[lpm_pkg::LPM_CNT_W-1:0])
		else $error("code 110 length wrong");

	COV_SLEEP: cover property (mode_r == lpm_pkg::LPM_SLEEP ##[1:20] mode_r == lpm_pkg::LPM_ACTIVE);
	COV_STANDBY: cover property (mode_r == lpm_pkg::LPM_SETTLE ##1 mode_r == lpm_pkg::LPM_ACTIVE);
	COV_WATCH_SUB: cover property (mode_r == lpm_pkg::LPM_WATCH ##1 mode_r == lpm_pkg::LPM_SUB_ACTIVE);

endmodule // lpm_mode_select

// File: sim/lpm_mode_select_bench.sv
// Self-checking bench for the low-power mode select block
`timescale 1ns/1ps
module lpm_mode_select_bench;
	// ----------------------------------------
	// Signals and shortened waits
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic sleep_exec_i = 1'b0;
	logic wake_irq_i = 1'b0;
	logic watch_enable_i = 1'b0;
	lpm_pkg::lpm_mode_t mode_o;
	logic cpu_hold_o;
	logic cpu_clk_sub_o;
	int mismatches = 0;
	int n_tests = 0;
	int exp_wait[8] = '{4, 5, 6, 7, 8, 2, 16, 8};
	logic [31:0] q;
	int n;

	lpm_mode_select #(.WAIT_000(4), .WAIT_001(5), .WAIT_010(6), .WAIT_011(7), .WAIT_100(8)) dut
	(
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sleep_exec_i(sleep_exec_i),
		.wake_irq_i(wake_irq_i), .watch_enable_i(watch_enable_i), .mode_o(mode_o),
		.cpu_hold_o(cpu_hold_o), .cpu_clk_sub_o(cpu_clk_sub_o)
	);

	initial
	begin
		forever #25 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic ev(input logic sl);
		@(posedge clk_i);
		if (sl)
			sleep_exec_i <= 1'b1;
		else
			wake_irq_i <= 1'b1;
		@(posedge clk_i);
		sleep_exec_i <= 1'b0;
		wake_irq_i <= 1'b0;
		@(negedge clk_i);
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h00, 4'hf, 8'h00);
		chk(q, 32'h0);
		wb(1'b0, 8'h04, 4'hf, 8'h00);
		chk(q, 32'h1);
		wb(1'b1, 8'h00, 4'hf, 8'hff);
		wb(1'b0, 8'h00, 4'hf, 8'h00);
		chk(q, 32'hf8);
		wb(1'b1, 8'h00, 4'he, 8'h00);
		wb(1'b0, 8'h00, 4'hf, 8'h00);
		chk(q, 32'hf8);
		wb(1'b0, 8'h10, 4'hf, 8'h00);
		chk(q, 32'h0);
		$display("test registers done");

		// Refused wake in active, plain sleep from active, then refused sleep
		wb(1'b1, 8'h00, 4'hf, 8'h00);
		ev(1'b0);
		chk(32'(mode_o), 32'h01);
		ev(1'b1);
		chk(32'(mode_o), 32'h02);
		chk(32'(cpu_hold_o), 32'h1);
		ev(1'b1);
		chk(32'(mode_o), 32'h02);
		ev(1'b0);
		chk(32'(mode_o), 32'h01);
		$display("test sleep done");

		// Every standby wait code
		for (int c = 0; c < 8; c++)
		begin
			wb(1'b1, 8'h00, 4'hf, {1'b1, 3'(c), 4'h0});
			ev(1'b1);
			chk(32'(mode_o), 32'h10);
			ev(1'b0);
			n = 0;
			while (mode_o === lpm_pkg::LPM_SETTLE && n < 50)
			begin
				chk(32'(cpu_hold_o), 32'h1);
				n++;
				@(negedge clk_i);
			end
			chk(32'(n), 32'(exp_wait[c]));
			chk(32'(mode_o), 32'h01);
		end
		$display("test standby waits done");

		// Watch and sub-active paths
		@(posedge clk_i);
		watch_enable_i <= 1'b1;
		wb(1'b1, 8'h00, 4'hf, 8'h88);
		ev(1'b1);
		chk(32'(mode_o), 32'h20);
		chk(32'(cpu_clk_sub_o), 32'h1);
		ev(1'b0);
		chk(32'(mode_o), 32'h04);
		wb(1'b0, 8'h04, 4'hf, 8'h00);
		chk(q, 32'h84);
		wb(1'b1, 8'h00, 4'hf, 8'h08);
		ev(1'b1);
		chk(32'(mode_o), 32'h08);
		ev(1'b0);
		chk(32'(mode_o), 32'h04);
		@(posedge clk_i);
		watch_enable_i <= 1'b0;
		wb(1'b1, 8'h00, 4'hf, 8'hd0);
		ev(1'b1);
		chk(32'(mode_o), 32'h20);
		chk(32'(cpu_clk_sub_o), 32'h0);
		ev(1'b0);
		chk(32'(mode_o), 32'h40);
		repeat (2) @(negedge clk_i);
		chk(32'(mode_o), 32'h01);
		chk(32'(cpu_clk_sub_o), 32'h0);
		$display("test watch done");
		tally_and_finish();
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		tally_and_finish();
	end
endmodule // lpm_mode_select_bench
